// ===== logic/timer_pkg.sv
// Contract
// - counter readable only: low byte bits 7..0, high register bits 1..0, rest zero
// - compare-A read/write in low/high registers, reset zero, unused bits zero
// - mode field: 00 compare, 10 pwm, 11 timer/counter
// - compare, clear-select low: clear on P match or overflow, both flags
// - compare, clear-select high: clear on A match, only A flag
// - compare-A zero: counter overflows at 3FF, no A flag
// - compare mode: after enable rising, pin changes only on A match flag
// - A match drives pin high, low, toggles, or no change by pin-function; with invert set the code's toggle leaves the pin unchanged and no-change toggles it
// - compare mode: enable rising loads pin with output-control level
// - timer/counter mode counts like compare mode, pin untouched
// - pwm ignores clear-select; swap bit picks period and duty register
// - pwm raises A flag on A match, P flag on P match
// - pwm: output-control active level, pin-function forces, invert bit
// - swap zero: period 128 times code, code zero 1024, duty compare-A
// - duty at or above period gives full duty
// - swap one: period compare-A, duty period code times 128
// - pwm counting and flags continue while pin forced by 00 or 01
// - enable rising clears counter; falling stops and retains value
// - period code compares with counter bits 9..7 only
// - pause holds counter, resumes from held value
`default_nettype none
package timer_pkg;
	// register byte addresses
	localparam logic [7:0] addr_counter_low  = 8'h00;
	localparam logic [7:0] addr_counter_high = 8'h04;
	localparam logic [7:0] addr_compare_low  = 8'h08;
	localparam logic [7:0] addr_compare_high = 8'h0C;
	localparam logic [7:0] addr_control_zero = 8'h10;
	localparam logic [7:0] addr_control_one  = 8'h14;
	localparam logic [7:0] addr_flags        = 8'h18;
	// control zero fields
	localparam int bit_pause     = 7;
	localparam int bit_enable    = 3;
	localparam int bit_period_hi = 2;
	// control one fields
	localparam int bit_mode_hi   = 7;
	localparam int bit_pin_hi    = 5;
	localparam int bit_out_ctrl  = 3;
	localparam int bit_invert    = 2;
	localparam int bit_swap      = 1;
	localparam int bit_clear_sel = 0;
	// flag register: write one to clear
	localparam int bit_flag_a    = 0;
	localparam int bit_flag_p    = 1;
	// counter geometry
	localparam int count_width   = 10;
	localparam int period_shift  = 7;
	localparam logic [9:0] count_max = 10'h3FF;
	// modes
	localparam logic [1:0] mode_compare = 2'h0;
	localparam logic [1:0] mode_pwm     = 2'h2;
	localparam logic [1:0] mode_timer   = 2'h3;
	// pin functions
	localparam logic [1:0] pin_none_or_inactive = 2'h0;
	localparam logic [1:0] pin_low_or_active    = 2'h1;
	localparam logic [1:0] pin_high_or_pwm      = 2'h2;
	localparam logic [1:0] pin_toggle           = 2'h3;
	localparam logic [7:0] byte_zero = 8'h00;
endpackage : timer_pkg
`default_nettype wire

// ===== logic/timer_match.sv
`default_nettype none
// --------------------------------------------
// comparators A and P against the counter
// --------------------------------------------
module timer_match (
	input  wire logic [9:0] count,
	input  wire logic [9:0] compare_a,
	input  wire logic [2:0] period_code,
	output logic            match_a,
	output logic            match_p,
	output logic            overflow,
	output logic [10:0]     period_clocks
);
	// period code compares with the top three counter bits only
	assign match_p  = (count[9:7] == period_code) && (period_code != 3'h0);
	assign match_a  = (count == compare_a) && (compare_a != 10'h000);
	assign overflow = (count == timer_pkg::count_max);
	// code zero means 1024 clocks
	assign period_clocks = (period_code == 3'h0) ? 11'h400
		: {1'b0, period_code, 7'h00};
endmodule : timer_match
`default_nettype wire

// ===== logic/timer_pwm_out.sv
`default_nettype none
// --------------------------------------------
// pwm waveform shaping
// --------------------------------------------
module timer_pwm_out (
	input  wire logic [9:0]  count,
	input  wire logic [10:0] duty,
	input  wire logic [10:0] period,
	input  wire logic [1:0]  pin_function,
	input  wire logic        active_high,
	output logic             level
);
	logic in_duty;
	logic active;
	// duty at or above period keeps the output active all period
	assign in_duty = ({1'b0, count} < duty) || (duty >= period);
	assign active  = (pin_function == timer_pkg::pin_low_or_active) ? 1'b1
		: (pin_function == timer_pkg::pin_none_or_inactive) ? 1'b0 : in_duty;
	assign level   = active ? active_high : ~active_high;
endmodule : timer_pwm_out
`default_nettype wire

// ===== logic/standard_timer.sv
// Decided for this implementation: the register offsets and register access over APB.
`default_nettype none
module standard_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             timer_out,
	output logic             timer_out_en,
	output logic             a_match_flag,
	output logic             p_match_flag
);
	// --------------------------------------------
	// state
	// --------------------------------------------
	typedef enum logic [2:0] {
		st_idle   = 3'b001,
		st_access = 3'b010,
		st_done   = 3'b100
	} bus_state_type;

	bus_state_type bus_state;
	bus_state_type next_bus_state;
	logic [9:0]  count;
	logic [9:0]  compare_a;
	logic [7:0]  control_zero;
	logic [7:0]  timer_control_one;
	logic        enable_prev;
	logic [9:0]  next_count;
	logic        next_out;
	logic [31:0] read_mux;

	// --------------------------------------------
	// field decode
	// --------------------------------------------
	logic       counter_enable;
	logic       counter_pause;
	logic [2:0] period_value;
	logic [1:0] mode_select;
	logic [1:0] pin_function;
	logic       output_control;
	logic       output_invert;
	logic       duty_period_swap;
	logic       clear_select;
	assign counter_enable   = control_zero[timer_pkg::bit_enable];
	assign counter_pause    = control_zero[timer_pkg::bit_pause];
	assign period_value     = control_zero[timer_pkg::bit_period_hi -: 3];
	assign mode_select      = timer_control_one[timer_pkg::bit_mode_hi -: 2];
	assign pin_function     = timer_control_one[timer_pkg::bit_pin_hi -: 2];
	assign output_control   = timer_control_one[timer_pkg::bit_out_ctrl];
	assign output_invert    = timer_control_one[timer_pkg::bit_invert];
	assign duty_period_swap = timer_control_one[timer_pkg::bit_swap];
	assign clear_select     = timer_control_one[timer_pkg::bit_clear_sel];

	logic is_compare;
	logic is_pwm;
	logic is_timer;
	assign is_compare = (mode_select == timer_pkg::mode_compare);
	assign is_pwm     = (mode_select == timer_pkg::mode_pwm);
	assign is_timer   = (mode_select == timer_pkg::mode_timer);

	// --------------------------------------------
	// comparators
	// --------------------------------------------
	logic        match_a;
	logic        match_p;
	logic        overflow;
	logic [10:0] period_clocks;
	timer_match u_match (
		.count         (count),
		.compare_a     (compare_a),
		.period_code   (period_value),
		.match_a       (match_a),
		.match_p       (match_p),
		.overflow      (overflow),
		.period_clocks (period_clocks)
	);

	// --------------------------------------------
	// counting and clearing
	// --------------------------------------------
	logic enable_rise;
	logic running;
	logic cm_like;
	logic clear_now;
	logic set_a;
	logic set_p;
	logic pwm_wrap;
	assign enable_rise = counter_enable && !enable_prev;
	assign running     = counter_enable && !counter_pause && !enable_rise;
	assign cm_like     = is_compare || is_timer;
	// pwm: wrap one clock before period end so the period is exactly the register value
	assign pwm_wrap    = duty_period_swap
		? ({1'b0, count} == {1'b0, compare_a} - 11'h001)
		: ({1'b0, count} == period_clocks - 11'h001);
	// the period comparator flags at the wrap, since the counter never reaches the period value
	logic pwm_a_hit;
	logic pwm_p_hit;
	assign pwm_a_hit = duty_period_swap ? pwm_wrap : match_a;
	assign pwm_p_hit = duty_period_swap ? match_p : pwm_wrap;
	assign clear_now = cm_like ? (clear_select ? match_a
		: (match_p || (period_value == 3'h0 && overflow)))
		: (is_pwm && pwm_wrap);
	// compare-A zero never matches so the counter rolls past 3FF
	assign set_a = running && (cm_like ? match_a : (is_pwm && pwm_a_hit));
	assign set_p = running && (cm_like ? (match_p && !clear_select) : (is_pwm && pwm_p_hit));
	assign next_count = enable_rise ? 10'h000
		: !running ? count
		: clear_now ? 10'h000 : count + 10'h001;

	// --------------------------------------------
	// pwm waveform
	// --------------------------------------------
	logic [10:0] duty_clocks;
	logic        pwm_level;
	assign duty_clocks = duty_period_swap ? period_clocks : {1'b0, compare_a};
	timer_pwm_out u_pwm (
		.count        (count),
		.duty         (duty_clocks),
		.period       (duty_period_swap ? {1'b0, compare_a} : period_clocks),
		.pin_function (pin_function),
		.active_high  (output_control),
		.level        (pwm_level)
	);

	// compare mode pin action on an A match
	logic cm_pin;
	assign cm_pin = (pin_function == timer_pkg::pin_low_or_active) ? 1'b0
		: (pin_function == timer_pkg::pin_high_or_pwm) ? 1'b1
		: (pin_function == timer_pkg::pin_toggle) ? ~timer_out : timer_out;
	// the pin in compare mode holds the raw level; invert applies at the pin
	logic raw_out;
	assign next_out = (is_compare && enable_rise) ? output_control
		: (is_compare && set_a) ? cm_pin
		: raw_out;

	// --------------------------------------------
	// apb decode
	// --------------------------------------------
	logic wr_access;
	logic rd_sel_ok;
	assign wr_access = psel && penable && pwrite && (bus_state == st_access);
	assign rd_sel_ok = (paddr == timer_pkg::addr_counter_low) || (paddr == timer_pkg::addr_counter_high)
		|| (paddr == timer_pkg::addr_compare_low) || (paddr == timer_pkg::addr_compare_high)
		|| (paddr == timer_pkg::addr_control_zero) || (paddr == timer_pkg::addr_control_one)
		|| (paddr == timer_pkg::addr_flags);
	assign read_mux =
		(paddr == timer_pkg::addr_counter_low)  ? {24'h0000_00, count[7:0]} :
		(paddr == timer_pkg::addr_counter_high) ? {30'h0000_0000, count[9:8]} :
		(paddr == timer_pkg::addr_compare_low)  ? {24'h0000_00, compare_a[7:0]} :
		(paddr == timer_pkg::addr_compare_high) ? {30'h0000_0000, compare_a[9:8]} :
		(paddr == timer_pkg::addr_control_zero) ? {24'h0000_00, control_zero} :
		(paddr == timer_pkg::addr_control_one)  ? {24'h0000_00, timer_control_one} :
		(paddr == timer_pkg::addr_flags)        ? {30'h0000_0000, p_match_flag, a_match_flag} :
		32'h0000_0000;

	// one wait state: setup, access, done
	always_comb begin
		case (bus_state)
			st_idle:   next_bus_state = (psel && !penable) ? st_access : st_idle;
			st_access: next_bus_state = st_done;
			st_done:   next_bus_state = st_idle;
			default:   next_bus_state = st_idle;
		endcase
	end

	// --------------------------------------------
	// bus and registers
	// --------------------------------------------
	logic clr_a;
	logic clr_p;
	assign clr_a = wr_access && (paddr == timer_pkg::addr_flags) && pwdata[timer_pkg::bit_flag_a];
	assign clr_p = wr_access && (paddr == timer_pkg::addr_flags) && pwdata[timer_pkg::bit_flag_p];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_state <= st_idle;
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else if (clk_en) begin
			bus_state <= next_bus_state;
			pready    <= (bus_state == st_access);
			pslverr   <= (bus_state == st_access) && !rd_sel_ok;
			prdata    <= (bus_state == st_access && !pwrite) ? read_mux : 32'h0000_0000;
		end
	end

	// software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_a         <= 10'h000;
			control_zero      <= timer_pkg::byte_zero;
			timer_control_one <= timer_pkg::byte_zero;
		end else if (clk_en && wr_access) begin
			if (paddr == timer_pkg::addr_compare_low)
				compare_a[7:0] <= pwdata[7:0];
			if (paddr == timer_pkg::addr_compare_high)
				compare_a[9:8] <= pwdata[1:0];
			if (paddr == timer_pkg::addr_control_zero)
				control_zero <= pwdata[7:0];
			if (paddr == timer_pkg::addr_control_one)
				timer_control_one <= pwdata[7:0];
		end
	end

	// counter, flags and pin; a set on the same edge as a clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count        <= 10'h000;
			enable_prev  <= 1'b0;
			a_match_flag <= 1'b0;
			p_match_flag <= 1'b0;
			raw_out      <= 1'b0;
		end else if (clk_en) begin
			count        <= next_count;
			enable_prev  <= counter_enable;
			a_match_flag <= set_a | (a_match_flag & ~clr_a);
			p_match_flag <= set_p | (p_match_flag & ~clr_p);
			raw_out      <= next_out;
		end
	end

	// pin register; the pin is released in timer/counter mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out    <= 1'b0;
			timer_out_en <= 1'b1;
		end else if (clk_en) begin
			timer_out    <= (is_pwm ? pwm_level : next_out) ^ output_invert;
			timer_out_en <= is_timer || !(is_compare || is_pwm);
		end
	end

	// --------------------------------------------
	// checks
	// --------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !clk_en);

	a_count_read_high: assert property ((bus_state == st_access && !pwrite && paddr == timer_pkg::addr_counter_high)
		|=> prdata[31:2] == 30'h0000_0000) else $error("counter high upper bits not zero");
	a_compare_write: assert property (wr_access && paddr == timer_pkg::addr_compare_low
		|=> compare_a[7:0] == $past(pwdata[7:0])) else $error("compare low not written");
	a_clear_on_p: assert property (running && cm_like && !clear_select && match_p
		|=> count == 10'h000 && p_match_flag) else $error("p match did not clear");
	a_no_p_flag: assert property (cm_like && clear_select && !clr_p && !p_match_flag
		|=> !p_match_flag) else $error("p flag raised with clear select");
	a_zero_compare: assert property (compare_a == 10'h000 && !a_match_flag && !clr_a && !is_pwm
		|=> !a_match_flag) else $error("a flag with zero compare");
	a_enable_restart: assert property (enable_rise |=> count == 10'h000) else $error("no restart");
	a_pause_hold: assert property (counter_pause && enable_prev && counter_enable
		|=> count == $past(count)) else $error("counter moved in pause");
	a_flag_sticky: assert property (a_match_flag && !clr_a |=> a_match_flag) else $error("a flag lost");
	a_initial_level: assert property (is_compare && enable_rise
		|=> ##1 timer_out == ($past(output_control, 2) ^ $past(output_invert, 2))) else $error("bad initial level");

	c_pwm_wrap: cover property (is_pwm && running && pwm_wrap);
	c_cm_toggle: cover property (is_compare && set_a && pin_function == timer_pkg::pin_toggle);
	c_overflow: cover property (cm_like && overflow && running && period_value == 3'h0);
endmodule : standard_timer
`default_nettype wire

// ===== test/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and bookkeeping
	// ----------------------------------------
	logic        pclk;
	logic        presetn;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        timer_out;
	logic        timer_out_en;
	logic        a_match_flag;
	logic        p_match_flag;
	logic [31:0] rd;
	logic [31:0] rd_old;
	logic        rd_err;
	int          err_count;
	int          num_checks;
	int          n;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic err;} row_type;
	row_type     rows [11];

	standard_timer standard_timer_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_out(timer_out), .timer_out_en(timer_out_en),
		.a_match_flag(a_match_flag), .p_match_flag(p_match_flag));

	// free-running bus clock, 8 ns period
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ----------------------------------------
	// compare, bus and wait helpers
	// ----------------------------------------
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkb

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int t;
		t = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20) chk(32'h0000_0bad, 32'h0000_0000);
		rd      = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// let one edge pass so a following call never reassigns psel in this time step
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr

	// stop the timer, clear flags, load compare-A, then program and start
	task automatic run(input logic [9:0] av, input logic [7:0] c1, input logic [7:0] c0);
		wr(timer_pkg::addr_control_zero, 32'h0000_0000);
		wr(timer_pkg::addr_flags, 32'h0000_0003);
		wr(timer_pkg::addr_compare_high, {30'h0, av[9:8]});
		wr(timer_pkg::addr_compare_low, {24'h0, av[7:0]});
		wr(timer_pkg::addr_control_one, {24'h0, c1});
		wr(timer_pkg::addr_control_zero, {24'h0, c0});
		repeat (2) @(posedge pclk);
	endtask : run

	// bounded wait on one of the sticky flags; n holds cycles waited
	task automatic wait_flag(input logic p);
		n = 0;
		while (((p ? p_match_flag : a_match_flag) !== 1'b1) && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		chkb(n < 2000, 1'b1);
	endtask : wait_flag

	// cycles with the pin high over one window
	task automatic count_high(input int len);
		n = 0;
		repeat (len) begin
			@(posedge pclk);
			if (timer_out === 1'b1) n++;
		end
	endtask : count_high

	// hang guard, far above the few thousand cycles the tests take
	initial begin
		repeat (50000) @(posedge pclk);
		err_count++;
		stop_test;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		err_count = 0;
		num_checks = 0;
		rows = '{'{8'h00, 0, 0, 0, 0}, '{8'h04, 0, 0, 0, 0}, '{8'h08, 0, 0, 0, 0}, '{8'h0C, 0, 0, 0, 0},
			'{8'h08, 1, 32'h0000_01A5, 0, 0}, '{8'h08, 0, 0, 32'h0000_00A5, 0},
			'{8'h0C, 1, 32'hFFFF_FFFF, 0, 0}, '{8'h0C, 0, 0, 32'h0000_0003, 0},
			'{8'h00, 1, 32'h0000_00FF, 0, 0}, '{8'h00, 0, 0, 0, 0}, '{8'h1C, 0, 0, 0, 1}};
		repeat (4) @(posedge pclk);
		chkb(timer_out_en, 1'b1);
		chkb(a_match_flag | p_match_flag | timer_out, 1'b0);
		presetn <= 1'b1;
		@(posedge pclk);
		// register table: reset values, access kinds, unmapped address
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			chkb(rd_err, rows[i].err);
			if (!rows[i].w) chk(rd, rows[i].e);
		end
		// compare mode, toggle on A, period code 1 clears at 128
		run(10'd64, 8'h38, 8'h09);
		chkb(timer_out_en, 1'b0);
		chkb(timer_out, 1'b1);
		wait_flag(1'b0);
		repeat (2) @(posedge pclk);
		chkb(timer_out, 1'b0);
		chkb(p_match_flag, 1'b0);
		wait_flag(1'b1);
		chkb(n > 50 && n < 70, 1'b1);
		apb(timer_pkg::addr_counter_low, 1'b0, 32'h0);
		chkb(rd < 8, 1'b1);
		chkb(timer_out, 1'b0);
		chkb(a_match_flag, 1'b1);
		wr(timer_pkg::addr_control_zero, 32'h0000_0001);
		wr(timer_pkg::addr_flags, 32'h0000_0003);
		chkb(a_match_flag | p_match_flag, 1'b0);
		apb(timer_pkg::addr_counter_low, 1'b0, 32'h0);
		rd_old = rd;
		repeat (20) @(posedge pclk);
		apb(timer_pkg::addr_counter_low, 1'b0, 32'h0);
		chk(rd, rd_old);
		// clear on A above the period value: no P flag
		run(10'd300, 8'h39, 8'h09);
		wait_flag(1'b0);
		repeat (400) @(posedge pclk);
		chkb(p_match_flag, 1'b0);
		apb(timer_pkg::addr_counter_high, 1'b0, 32'h0);
		chkb(rd < 2, 1'b1);
		// compare-A zero: free run to overflow, no A flag, pin untouched
		run(10'd0, 8'h38, 8'h08);
		repeat (1100) @(posedge pclk);
		chkb(a_match_flag, 1'b0);
		chkb(timer_out, 1'b1);
		// timer/counter mode: flags yes, pin released
		run(10'd64, 8'hF8, 8'h09);
		wait_flag(1'b0);
		chkb(timer_out_en, 1'b1);
		wr(timer_pkg::addr_control_zero, 32'h0000_0089);
		apb(timer_pkg::addr_counter_low, 1'b0, 32'h0);
		rd_old = rd;
		repeat (10) @(posedge pclk);
		apb(timer_pkg::addr_counter_low, 1'b0, 32'h0);
		chk(rd, rd_old);
		wr(timer_pkg::addr_control_zero, 32'h0000_0009);
		repeat (10) @(posedge pclk);
		apb(timer_pkg::addr_counter_low, 1'b0, 32'h0);
		chkb(rd !== rd_old, 1'b1);
		// pwm: duty, full duty, invert, swap, forced inactive
		run(10'd32, 8'hA9, 8'h09);
		count_high(128);
		chk(n, 32);
		chkb(a_match_flag & p_match_flag, 1'b1);
		run(10'd200, 8'hA8, 8'h09);
		count_high(128);
		chk(n, 128);
		run(10'd32, 8'hAC, 8'h09);
		count_high(128);
		chk(n, 96);
		run(10'd256, 8'hAA, 8'h09);
		count_high(256);
		chk(n, 128);
		run(10'd32, 8'h88, 8'h09);
		count_high(128);
		chk(n, 0);
		chkb(a_match_flag & p_match_flag, 1'b1);
		stop_test;
	end
endmodule : testbench
`default_nettype wire
